//--- src/serial_flash_write_protect.sv
// write-protect and address decode for a serial flash array
// Notes on behaviour
// RULE_01 - sector is address bits 22:16, subsector bits 22:12; 16 per sector
// RULE_02 - modifying commands run only if selected clock count is byte whole
// RULE_03 - write enable latch must be set before any modifying command
// RULE_04 - no modification until power-on hold-off timer has expired
// RULE_05 - per-sector volatile lock bit; 1 protects from program and erase
// RULE_06 - lock-down bit freezes lock bits until power cycle or reset
// RULE_07 - lock bits change only by lock write, ignored when locked down
// RULE_08 - bottom select 0: codes 1..7 protect top 1..64 sectors
// RULE_09 - protect size msb set protects every sector
// RULE_10 - bottom select 1: codes 1..7 protect lowest 1..64 sectors
// RULE_11 - program clears bits only; erase sets; no page erase exists
// RULE_12 - reject if target sector protected; bulk erase if any protected
`timescale 1ns/1ns
module serial_flash_write_protect
(
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  input  wire logic        i_sclk,
  input  wire logic        i_select_n,
  input  wire logic        i_cmd_valid,
  input  wire logic [2:0]  i_cmd_op,
  input  wire logic [23:0] i_cmd_addr,
  input  wire logic        i_cmd_lock_value,
  input  wire logic        i_cmd_lock_down,
  input  wire logic        i_write_enable_latch,
  input  wire logic        i_protect_size_msb,
  input  wire logic        i_protect_size_bit2,
  input  wire logic        i_protect_size_bit1,
  input  wire logic        i_protect_size_lsb,
  input  wire logic        i_top_bottom_select,
  output logic             o_grant,
  output logic             o_reject,
  output logic [6:0]       o_sector,
  output logic [10:0]      o_subsector,
  output logic             o_program_clears_only,
  output logic [127:0]     o_lock_bits,
  output logic             o_lock_down,
  output logic             o_ready
);
  // pin synchronisers: first stage read only by second
  logic [1:0] sclk_sync_q;
  logic [1:0] sel_sync_q;
  logic       sclk_prev_q;
  logic       sclk_prev_d;

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      sclk_sync_q <= 2'h0;
      sel_sync_q  <= 2'h3;
    end
    else
    begin
      sclk_sync_q <= {sclk_sync_q[0], i_sclk};
      sel_sync_q  <= {sel_sync_q[0], i_select_n};
    end
  end

  logic sclk_rise;
  logic selected;
  assign selected  = ~sel_sync_q[1];
  assign sclk_rise = sclk_sync_q[1] & ~sclk_prev_q;
  assign sclk_prev_d = sclk_sync_q[1];

  // power-on hold-off
  logic [flash_protect_pkg::POR_CNT_W-1:0] por_cnt_q;
  logic [flash_protect_pkg::POR_CNT_W-1:0] por_cnt_d;
  logic                                    ready_q;
  logic                                    ready_d;

  always_comb
  begin
    por_cnt_d = por_cnt_q;
    ready_d   = ready_q;
    if (por_cnt_q ==
        flash_protect_pkg::POR_CNT_W'(flash_protect_pkg::POR_HOLD_CYC - 1))
    begin
      ready_d = 1'b1; // RULE_04
    end
    else
    begin
      por_cnt_d = por_cnt_q + 1'b1;
    end
  end

  // bit counter over a select frame
  logic [flash_protect_pkg::BIT_CNT_W-1:0] bit_cnt_q;
  logic [flash_protect_pkg::BIT_CNT_W-1:0] bit_cnt_d;
  flash_protect_pkg::frame_state_t         state_q;
  flash_protect_pkg::frame_state_t         state_d;

  always_comb
  begin
    state_d   = state_q;
    bit_cnt_d = bit_cnt_q;
    case (state_q)
      flash_protect_pkg::ST_IDLE:
      begin
        bit_cnt_d = '0;
        if (selected)
        begin
          state_d = flash_protect_pkg::ST_SEL;
        end
      end
      flash_protect_pkg::ST_SEL:
      begin
        if (sclk_rise)
        begin
          bit_cnt_d = bit_cnt_q + 1'b1; // RULE_02
        end
        if (!selected)
        begin
          state_d = flash_protect_pkg::ST_DONE;
        end
      end
      flash_protect_pkg::ST_DONE:
      begin
        state_d = flash_protect_pkg::ST_IDLE;
      end
      default:
      begin
        state_d = flash_protect_pkg::ST_IDLE;
      end
    endcase
  end

  // address decode and protection check
  logic [6:0]  sector;
  logic [10:0] subsector;
  logic        bp_hit;
  logic        any_bp;
  logic        any_lock;
  logic        target_prot;
  logic        whole_bytes;
  logic        permitted;
  logic        is_lock_cmd;
  logic        is_bulk;

  // array is 23 bits wide; address bit 23 is outside every sector
  assign sector    = i_cmd_addr[flash_protect_pkg::SECTOR_LSB +:
                                flash_protect_pkg::SECTOR_W]; // RULE_01
  assign subsector = i_cmd_addr[flash_protect_pkg::SUBSECTOR_LSB +:
                                flash_protect_pkg::SUBSECTOR_W]; // RULE_01

  protect_area_decode u_decode
  (
    .i_sector            (sector),
    .i_protect_size_msb  (i_protect_size_msb),
    .i_protect_size_bit2 (i_protect_size_bit2),
    .i_protect_size_bit1 (i_protect_size_bit1),
    .i_protect_size_lsb  (i_protect_size_lsb),
    .i_top_bottom_select (i_top_bottom_select),
    .o_protected         (bp_hit)
  );

  logic [127:0] lock_q;
  logic [127:0] lock_d;
  logic         lock_down_q;
  logic         lock_down_d;

  // any block-protect code other than none covers at least one sector
  assign any_bp = i_protect_size_msb | i_protect_size_bit2 |
                  i_protect_size_bit1 | i_protect_size_lsb;
  assign any_lock    = |lock_q;
  assign target_prot = bp_hit | lock_q[sector]; // RULE_05
  assign whole_bytes = (bit_cnt_q == '0); // RULE_02
  assign is_lock_cmd = (i_cmd_op == 3'(flash_protect_pkg::OP_LOCK_WRITE));
  assign is_bulk     = (i_cmd_op == 3'(flash_protect_pkg::OP_ERASE_BULK));

  always_comb
  begin
    permitted = ready_q & whole_bytes & i_write_enable_latch; // RULE_03
    if (is_lock_cmd)
    begin
      permitted = permitted & ~lock_down_q; // RULE_07
    end
    else if (is_bulk)
    begin
      permitted = permitted & ~any_bp & ~any_lock; // RULE_12
    end
    else if (i_cmd_op != 3'(flash_protect_pkg::OP_REG_WRITE))
    begin
      permitted = permitted & ~target_prot; // RULE_12
    end
  end

  // command decisions are taken once, at the end of a frame
  logic cmd_end;
  assign cmd_end = (state_q == flash_protect_pkg::ST_DONE) & i_cmd_valid;

  logic grant_d;
  logic reject_d;
  logic [6:0]  sector_q;
  logic [10:0] subsector_q;
  logic grant_q;
  logic reject_q;

  always_comb
  begin
    lock_d      = lock_q;
    lock_down_d = lock_down_q;
    grant_d     = cmd_end & permitted;
    reject_d    = cmd_end & ~permitted;
    if (grant_d && is_lock_cmd)
    begin
      lock_d[sector] = i_cmd_lock_value; // RULE_07
      lock_down_d    = i_cmd_lock_down; // RULE_06
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      sclk_prev_q <= 1'b0;
      por_cnt_q   <= '0;
      ready_q     <= 1'b0;
      bit_cnt_q   <= '0;
      state_q     <= flash_protect_pkg::ST_IDLE;
      lock_q      <= flash_protect_pkg::LOCK_RESET; // RULE_06
      lock_down_q <= 1'b0;
      grant_q     <= 1'b0;
      reject_q    <= 1'b0;
      sector_q    <= '0;
      subsector_q <= '0;
    end
    else
    begin
      sclk_prev_q <= sclk_prev_d;
      por_cnt_q   <= por_cnt_d;
      ready_q     <= ready_d;
      bit_cnt_q   <= bit_cnt_d;
      state_q     <= state_d;
      lock_q      <= lock_d;
      lock_down_q <= lock_down_d;
      grant_q     <= grant_d;
      reject_q    <= reject_d;
      sector_q    <= sector;
      subsector_q <= subsector; // RULE_01
    end
  end

  assign o_grant     = grant_q;
  assign o_reject    = reject_q;
  assign o_sector    = sector_q;
  assign o_subsector = subsector_q;
  assign o_lock_bits = lock_q;
  assign o_lock_down = lock_down_q;
  assign o_ready     = ready_q;
  // programming only clears bits; array updater ands the data in
  assign o_program_clears_only = ready_q; // RULE_11
endmodule : serial_flash_write_protect

//--- pkg/flash_protect_pkg.sv
// constants for the flash write-protect block
package flash_protect_pkg;
  localparam int unsigned ADDR_W         = 24;
  localparam int unsigned SECTOR_W       = 7;
  localparam int unsigned SUBSECTOR_W    = 11;
  localparam int unsigned NUM_SECTORS    = 128;
  localparam int unsigned SECTOR_LSB     = 16;
  localparam int unsigned SUBSECTOR_LSB  = 12;
  localparam int unsigned BIT_CNT_W      = 3;
  localparam logic [3:0]  PROTECT_NONE   = 4'h0;
  // power-on hold-off time and derived cycle count at 10 MHz
  localparam int unsigned POR_HOLD_US    = 100;
  localparam int unsigned CLK_MHZ        = 10;
  localparam int unsigned POR_HOLD_CYC   = POR_HOLD_US * CLK_MHZ;
  localparam int unsigned POR_CNT_W      = 10;
  localparam logic [NUM_SECTORS-1:0] LOCK_RESET = '0;

  typedef enum logic [2:0]
  {
    OP_PROGRAM     = 3'h0,
    OP_ERASE_SUB   = 3'h1,
    OP_ERASE_SECT  = 3'h2,
    OP_ERASE_BULK  = 3'h3,
    OP_REG_WRITE   = 3'h4,
    OP_LOCK_WRITE  = 3'h5
  } op_t;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_SEL  = 3'b010,
    ST_DONE = 3'b100
  } frame_state_t;
endpackage : flash_protect_pkg

//--- src/protect_area_decode.sv
// block-protect area decode for one sector number
`timescale 1ns/1ns
module protect_area_decode
(
  input  wire logic [6:0] i_sector,
  input  wire logic       i_protect_size_msb,
  input  wire logic       i_protect_size_bit2,
  input  wire logic       i_protect_size_bit1,
  input  wire logic       i_protect_size_lsb,
  input  wire logic       i_top_bottom_select,
  output logic            o_protected
);
  logic [2:0] code;
  logic [7:0] span;
  logic [7:0] sec;

  always_comb
  begin
    code = {i_protect_size_bit2, i_protect_size_bit1, i_protect_size_lsb};
    sec  = {1'b0, i_sector};
    span = (code == 3'h0) ? 8'h00 : 8'(8'h01 << (code - 3'h1));
    if (i_protect_size_msb)
    begin
      o_protected = 1'b1; // RULE_09
    end
    else if (code == 3'h0)
    begin
      o_protected = 1'b0;
    end
    else if (i_top_bottom_select)
    begin
      o_protected = (sec < span); // RULE_10
    end
    else
    begin
      o_protected = (sec >= (8'h80 - span)); // RULE_08
    end
  end
endmodule : protect_area_decode

//--- dv/serial_flash_write_protect_monitor.sv
// concurrent checks on the write-protect block ports
`timescale 1ns/1ns
module serial_flash_write_protect_monitor
(
  input wire logic         i_clk,
  input wire logic         i_srst,
  input wire logic [2:0]   i_cmd_op,
  input wire logic [23:0]  i_cmd_addr,
  input wire logic         i_write_enable_latch,
  input wire logic         i_protect_size_msb,
  input wire logic         o_grant,
  input wire logic         o_reject,
  input wire logic [6:0]   o_sector,
  input wire logic [10:0]  o_subsector,
  input wire logic [127:0] o_lock_bits,
  input wire logic         o_lock_down,
  input wire logic         o_ready
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  sequence s_decide;
    o_grant || o_reject;
  endsequence
  sequence s_lock_edit;
    $changed(o_lock_bits) || $changed(o_lock_down);
  endsequence
  chk_pulse_once: assert property (
    s_decide |=> !(o_grant || o_reject))
    else $error("decision pulse too long");
  chk_grant_ready: assert property (o_grant |-> o_ready)
    else $error("grant before ready");
  chk_grant_latch: assert property (
    o_grant |-> $past(i_write_enable_latch))
    else $error("grant with latch clear");
  chk_all_protect: assert property (
    o_grant && $past(i_protect_size_msb) |->
      $past(i_cmd_op) inside {3'h4, 3'h5})
    else $error("array write granted while all protected");
  chk_sector_map: assert property (
    !$past(i_srst) |-> o_sector == $past(i_cmd_addr[22:16]))
    else $error("sector decode wrong");
  chk_sub_map: assert property (
    !$past(i_srst) |-> o_subsector == $past(i_cmd_addr[22:12]))
    else $error("subsector decode wrong");
  chk_lock_frozen: assert property (
    o_lock_down |=> $stable(o_lock_bits))
    else $error("lock bits moved while locked down");
  chk_lock_cause: assert property (
    s_lock_edit |-> o_grant && $past(i_cmd_op) == 3'h5)
    else $error("lock state changed without lock write");
endmodule : serial_flash_write_protect_monitor

bind serial_flash_write_protect serial_flash_write_protect_monitor mon (.*);

//--- dv/spi_master_model.sv
// command-issuing master on the serial side, mode 0
`timescale 1ns/1ns
module spi_master_model
(
  output logic o_sclk,
  output logic o_select_n
);
  // pull-down on clock, pull-up on select while idle
  initial
  begin
    o_sclk = 1'b0;
    o_select_n = 1'b1;
  end
  // clock stands still between frames
  task automatic frame(input int n);
    #17 o_select_n = 1'b0;
    repeat (n)
    begin
      #400 o_sclk = 1'b1;
      #400 o_sclk = 1'b0;
    end
    #400 o_select_n = 1'b1;
  endtask : frame
endmodule : spi_master_model

//--- dv/serial_flash_write_protect_tb.sv
// self-checking bench for the flash write-protect block
`timescale 1ns/1ns
module serial_flash_write_protect_tb;
  typedef struct {
    logic [2:0] op; logic [23:0] a; logic [3:0] bp;
    logic bot; logic we; int n; logic ex;
  } row_t;
  logic i_clk = 1'b0, i_srst = 1'b1, i_cmd_valid = 1'b0;
  logic [2:0] i_cmd_op = 3'h0;
  logic [23:0] i_cmd_addr = 24'h0;
  logic i_cmd_lock_value = 1'b0, i_cmd_lock_down = 1'b0;
  logic i_write_enable_latch = 1'b0, i_top_bottom_select = 1'b0;
  logic i_protect_size_msb = 1'b0, i_protect_size_bit2 = 1'b0;
  logic i_protect_size_bit1 = 1'b0, i_protect_size_lsb = 1'b0;
  wire i_sclk, i_select_n;
  logic o_grant, o_reject, o_program_clears_only, o_lock_down, o_ready;
  logic [6:0] o_sector;
  logic [10:0] o_subsector;
  logic [127:0] o_lock_bits;
  int errors = 0, checks_done = 0, cyc = 0;
  row_t rows[16] = '{
    '{3'h0, 24'h7f0000, 4'h1, 0, 1, 8, 0},
    '{3'h0, 24'h7effff, 4'h1, 0, 1, 8, 1},
    '{3'h1, 24'h400000, 4'h7, 0, 1, 8, 0},
    '{3'h2, 24'h3f0000, 4'h7, 0, 1, 8, 1},
    '{3'h1, 24'h000fff, 4'h1, 1, 1, 8, 0},
    '{3'h2, 24'h010000, 4'h1, 1, 1, 8, 1},
    '{3'h0, 24'h3fffff, 4'h7, 1, 1, 8, 0},
    '{3'h0, 24'h400000, 4'h7, 1, 1, 8, 1},
    '{3'h0, 24'h400000, 4'hf, 0, 1, 8, 0},
    '{3'h2, 24'h7f0000, 4'h8, 1, 1, 8, 0},
    '{3'h4, 24'h000000, 4'hf, 1, 1, 8, 1},
    '{3'h0, 24'h100000, 4'h0, 0, 0, 8, 0},
    '{3'h0, 24'h100000, 4'h0, 0, 1, 12, 0},
    '{3'h4, 24'h000000, 4'h0, 0, 1, 16, 1},
    '{3'h3, 24'h000000, 4'h1, 1, 1, 8, 0},
    '{3'h3, 24'h000000, 4'h0, 0, 1, 8, 1}};
  serial_flash_write_protect dut (.*);
  spi_master_model spi (.o_sclk(i_sclk), .o_select_n(i_select_n));
  always #50 i_clk = ~i_clk;
  always @(posedge i_clk) cyc <= i_srst ? 0 : cyc + 1;
  task automatic chk(string s, logic [127:0] e, logic [127:0] v);
    checks_done++;
    if (v !== e)
    begin
      errors++;
      $display("FAIL %s expected %h seen %h", s, e, v);
    end
  endtask : chk
  // command inputs held for the whole frame and decision
  task automatic cmd(row_t r);
    @(posedge i_clk);
    i_cmd_op <= r.op;
    i_cmd_addr <= r.a;
    {i_protect_size_msb, i_protect_size_bit2} <= r.bp[3:2];
    {i_protect_size_bit1, i_protect_size_lsb} <= r.bp[1:0];
    i_top_bottom_select <= r.bot;
    i_write_enable_latch <= r.we;
    i_cmd_valid <= 1'b1;
    spi.frame(r.n);
    repeat (30)
    begin
      @(posedge i_clk);
      #1;
      if (o_grant || o_reject) break;
    end
    chk("decision", 128'({r.ex, !r.ex}), 128'({o_grant, o_reject}));
    chk("sector", 128'(r.a[22:16]), 128'(o_sector));
    chk("subsector", 128'(r.a[22:12]), 128'(o_subsector));
    @(posedge i_clk);
    i_cmd_valid <= 1'b0;
    repeat (4) @(posedge i_clk);
  endtask : cmd
  task automatic wrap_up;
    if (errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  initial
  begin
    #600000;
    errors++;
    wrap_up;
  end
  initial
  begin
    repeat (10) @(posedge i_clk);
    i_srst <= 1'b0;
    cmd('{3'h4, 24'h0, 4'h0, 0, 1, 8, 0});
    // sampled just after each edge so the first ready cycle is seen
    while (o_ready !== 1'b1 && cyc < 1100)
    begin
      @(posedge i_clk);
      #1;
    end
    chk("ready", 128'(flash_protect_pkg::POR_HOLD_CYC), 128'(cyc));
    chk("clears only", 128'(1), 128'(o_program_clears_only));
    foreach (rows[i]) cmd(rows[i]);
    i_cmd_lock_value <= 1'b1;
    cmd('{3'h5, 24'h050000, 4'h0, 0, 1, 8, 1});
    chk("lock bits", 128'h20, o_lock_bits);
    cmd('{3'h0, 24'h05abcd, 4'h0, 0, 1, 8, 0});
    cmd('{3'h3, 24'h000000, 4'h0, 0, 1, 8, 0});
    i_cmd_lock_value <= 1'b0;
    i_cmd_lock_down <= 1'b1;
    cmd('{3'h5, 24'h050000, 4'h0, 0, 1, 8, 1});
    chk("lock down", 128'h1, 128'(o_lock_down));
    i_cmd_lock_value <= 1'b1;
    cmd('{3'h5, 24'h060000, 4'h0, 0, 1, 8, 0});
    chk("frozen bits", 128'h0, o_lock_bits);
    i_srst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_srst <= 1'b0;
    @(posedge i_clk);
    #1;
    chk("after reset", 128'h0, 128'({o_lock_down, o_ready}));
    wrap_up;
  end
endmodule : serial_flash_write_protect_tb
